/* File: svrc_control.sv */
`timescale 1ns/10ps

// Function
// - Writing channel_enable 1 starts negotiation, sets negotiation_pending; enable resets 0.
// - channel_identifier bits 26:24, read/write, resets 001; 000 reserved.
// - Scheme select bits 19:17; 000 fixed round-robin, 100 time-based WRR.
// - Scheme select equals the chosen scheme's bit index in capability field.
// - Writing 1 to table load bit 16 commits staged entries to arbiter.
// - Table load bit is a self-clearing strobe, always reads 0.
// - traffic_class_map bits 7:0, one bit per class mapped here.
// - Traffic class 0 bit is read-only zero; bits 7:1 writable.
// - traffic_class_map resets to 00h.
// - Reserved bits 30:27, 23:20, 15:8 read as zero.
// - Register at 170h resets to 0100_0000h.
// - negotiation_pending high while negotiation runs after enable, else zero.
// - Table dirty flag set on staged entry write, cleared after refresh.
// - Port arbitration capability reads 11h.
module svrc_control
    import svrc_pkg::*;
(
    input  wire logic                       clk_sys_i,          // System clock
    input  wire logic                       reset_i,            // Async reset, high
    input  wire svrc_pkg::svrc_cfg_req_type cfg_req_i,          // Config access
    input  wire logic                       table_entry_write_i,// Staged entry written
    input  wire logic                       table_load_done_i,  // Arbiter refresh done
    input  wire logic                       negotiation_done_i, // Link negotiation done
    output logic [31:0]                     cfg_rdata_o,        // Read data
    output logic                            cfg_rvalid_o,       // Read data valid
    output logic                            channel_enable_o,   // Channel enabled
    output logic [2:0]                      channel_identifier_o, // Channel ID
    output logic [2:0]                      port_arbitration_scheme_select_o, // Scheme
    output logic [7:0]                      scheme_onehot_o,    // Active scheme bit
    output logic [7:0]                      traffic_class_map_o,// Mapped classes
    output logic                            table_load_o,       // Table commit pulse
    output logic                            negotiation_pending_o, // Negotiating
    output logic                            arbitration_table_dirty_o, // Table dirty
    output logic [7:0]                      port_arbitration_capability_o // Capability
);
    import svrc_pkg::*;

    svrc_ctrl_type ctrl_q;
    svrc_ctrl_type ctrl_d;
    logic          load_q;
    logic          load_d;
    logic          pending_q;
    logic          pending_d;
    logic          dirty_q;
    logic          dirty_d;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic          rvalid_q;
    logic          rvalid_d;
    logic [7:0]    onehot_q;
    logic [7:0]    onehot_d;
    logic          hit_wr;
    logic          hit_rd;

    // Packs the control fields; unlisted positions stay zero
    function automatic logic [31:0] svrc_pack(input svrc_ctrl_type c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SVRC_EN_BIT] = c.en;
        w[SVRC_ID_MSB:SVRC_ID_LSB] = c.id;
        w[SVRC_SEL_MSB:SVRC_SEL_LSB] = c.sel;
        w[SVRC_TCMAP_MSB:SVRC_TCMAP_LSB] = c.tcmap;
        return w;
    endfunction : svrc_pack

    // Decodes a scheme index into the capability bit it names
    function automatic logic [7:0] svrc_scheme_bit(input logic [2:0] sel);
        logic [7:0] b;
        b = 8'h01 << sel;
        return b;
    endfunction : svrc_scheme_bit

    assign hit_wr = cfg_req_i.wr && (cfg_req_i.addr == SVRC_CTRL_OFFSET);
    assign hit_rd = cfg_req_i.rd && (cfg_req_i.addr == SVRC_CTRL_OFFSET);

    always_comb begin
        ctrl_d    = ctrl_q;
        load_d    = 1'b0;
        pending_d = pending_q;
        dirty_d   = dirty_q;
        rdata_d   = rdata_q;
        rvalid_d  = 1'b0;
        onehot_d  = 8'h00;
        if (hit_wr && cfg_req_i.be[3]) begin
            ctrl_d.en = cfg_req_i.wdata[SVRC_EN_BIT];
            // Zero ID is reserved; a write of 000 keeps the old one
            if (cfg_req_i.wdata[SVRC_ID_MSB:SVRC_ID_LSB] != SVRC_ID_RESERVED) begin
                ctrl_d.id = cfg_req_i.wdata[SVRC_ID_MSB:SVRC_ID_LSB];
            end
        end
        if (hit_wr && cfg_req_i.be[2]) begin
            ctrl_d.sel = cfg_req_i.wdata[SVRC_SEL_MSB:SVRC_SEL_LSB];
            load_d     = cfg_req_i.wdata[SVRC_LOAD_BIT];
        end
        if (hit_wr && cfg_req_i.be[0]) begin
            ctrl_d.tcmap = cfg_req_i.wdata[SVRC_TCMAP_MSB:SVRC_TCMAP_LSB]
                           & SVRC_TCMAP_WMASK;
        end
        // Done clears, a fresh enable request wins in the same cycle
        if (negotiation_done_i) begin
            pending_d = 1'b0;
        end
        if (!ctrl_d.en) begin
            pending_d = 1'b0;
        end
        if (hit_wr && cfg_req_i.be[3] && cfg_req_i.wdata[SVRC_EN_BIT]) begin
            pending_d = 1'b1;
        end
        if (table_load_done_i) begin
            dirty_d = 1'b0;
        end
        if (table_entry_write_i) begin
            dirty_d = 1'b1;
        end
        if (cfg_req_i.rd) begin
            rvalid_d = 1'b1;
            rdata_d  = hit_rd ? svrc_pack(ctrl_q) : 32'h0000_0000;
        end
        // Unsupported encodings select no scheme rather than a wrong one
        onehot_d = svrc_scheme_bit(ctrl_d.sel) & SVRC_ARB_CAP;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q.en    <= SVRC_CTRL_RESET[SVRC_EN_BIT];
            ctrl_q.id    <= SVRC_ID_RESET;
            ctrl_q.sel   <= SVRC_SEL_FIXED_RR;
            ctrl_q.tcmap <= SVRC_TCMAP_RESET;
            load_q       <= 1'b0;
            pending_q    <= 1'b0;
            dirty_q      <= 1'b0;
            rdata_q      <= 32'h0000_0000;
            rvalid_q     <= 1'b0;
            onehot_q     <= 8'h01;
        end else begin
            ctrl_q    <= ctrl_d;
            load_q    <= load_d;
            pending_q <= pending_d;
            dirty_q   <= dirty_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
            onehot_q  <= onehot_d;
        end
    end

    logic [7:0] cap_q;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cap_q <= SVRC_ARB_CAP;
        end else begin
            cap_q <= SVRC_ARB_CAP;
        end
    end

    assign cfg_rdata_o                      = rdata_q;
    assign cfg_rvalid_o                     = rvalid_q;
    assign channel_enable_o                 = ctrl_q.en;
    assign channel_identifier_o             = ctrl_q.id;
    assign port_arbitration_scheme_select_o = ctrl_q.sel;
    assign scheme_onehot_o                  = onehot_q;
    assign traffic_class_map_o              = ctrl_q.tcmap;
    assign table_load_o                     = load_q;
    assign negotiation_pending_o            = pending_q;
    assign arbitration_table_dirty_o        = dirty_q;
    assign port_arbitration_capability_o    = cap_q;

endmodule : svrc_control

/* File: svrc_pkg.sv */
package svrc_pkg;

    localparam logic [11:0] SVRC_CTRL_OFFSET    = 12'h170;
    localparam logic [31:0] SVRC_CTRL_RESET     = 32'h0100_0000;

    localparam int          SVRC_EN_BIT         = 31;
    localparam int          SVRC_ID_LSB         = 24;
    localparam int          SVRC_ID_MSB         = 26;
    localparam int          SVRC_SEL_LSB        = 17;
    localparam int          SVRC_SEL_MSB        = 19;
    localparam int          SVRC_LOAD_BIT       = 16;
    localparam int          SVRC_TCMAP_LSB      = 0;
    localparam int          SVRC_TCMAP_MSB      = 7;

    localparam logic [2:0]  SVRC_ID_RESET       = 3'h1;
    localparam logic [2:0]  SVRC_ID_RESERVED    = 3'h0;
    localparam logic [2:0]  SVRC_SEL_FIXED_RR   = 3'h0;
    localparam logic [2:0]  SVRC_SEL_TIME_WRR   = 3'h4;
    localparam logic [7:0]  SVRC_TCMAP_RESET    = 8'h00;
    localparam logic [7:0]  SVRC_TCMAP_WMASK    = 8'hfe;
    localparam logic [7:0]  SVRC_ARB_CAP        = 8'h11;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } svrc_cfg_req_type;

    typedef struct packed {
        logic        en;
        logic [2:0]  id;
        logic [2:0]  sel;
        logic [7:0]  tcmap;
    } svrc_ctrl_type;

endpackage : svrc_pkg

/* File: svrc_control_props.sv */
`timescale 1ns/10ps
module svrc_control_props
    import svrc_pkg::*;
(
    input wire logic                       clk_sys_i,
    input wire logic                       reset_i,
    input wire svrc_pkg::svrc_cfg_req_type cfg_req_i,
    input wire logic                       table_entry_write_i,
    input wire logic                       negotiation_done_i,
    input wire logic [31:0]                cfg_rdata_o,
    input wire logic                       cfg_rvalid_o,
    input wire logic                       channel_enable_o,
    input wire logic [2:0]                 channel_identifier_o,
    input wire logic [2:0]                 port_arbitration_scheme_select_o,
    input wire logic [7:0]                 scheme_onehot_o,
    input wire logic [7:0]                 traffic_class_map_o,
    input wire logic                       table_load_o,
    input wire logic                       negotiation_pending_o,
    input wire logic                       arbitration_table_dirty_o,
    input wire logic [7:0]                 port_arbitration_capability_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic wr_hit;
    assign wr_hit = cfg_req_i.wr && cfg_req_i.addr == 12'h170;
    enable_starts_a: assert property (wr_hit && cfg_req_i.be[3] && cfg_req_i.wdata[31]
        |=> channel_enable_o && negotiation_pending_o) else $error("enable write lost");
    // Back-to-back loads legally stretch the pulse
    load_strobe_a: assert property (wr_hit && cfg_req_i.be[2] && cfg_req_i.wdata[16]
        ##1 !wr_hit |-> table_load_o ##1 !table_load_o) else $error("load strobe wrong");
    rsvd_zero_a: assert property (cfg_rvalid_o |-> (cfg_rdata_o & 32'h78f1_ff01) == 32'h0)
        else $error("reserved read bits set");
    id_nonzero_a: assert property (channel_identifier_o != 3'h0)
        else $error("channel id zero");
    tc0_zero_a: assert property (!traffic_class_map_o[0])
        else $error("class 0 mapped");
    cap_const_a: assert property (port_arbitration_capability_o == 8'h11)
        else $error("capability wrong");
    onehot_sel_a: assert property (scheme_onehot_o == (8'h11
        & (8'h1 << port_arbitration_scheme_select_o))) else $error("scheme bit wrong");
    dirty_set_a: assert property (table_entry_write_i |=> arbitration_table_dirty_o)
        else $error("dirty not set");
    pend_clear_a: assert property (negotiation_done_i && !wr_hit |=> !negotiation_pending_o)
        else $error("pending not cleared");
    cover property (table_load_o);
    cover property (negotiation_pending_o ##1 !negotiation_pending_o);
    cover property (arbitration_table_dirty_o ##1 !arbitration_table_dirty_o);
endmodule : svrc_control_props
bind svrc_control svrc_control_props svrc_control_props_i (.*);

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
    import svrc_pkg::*;
    logic             clk_sys_i, reset_i, cfg_rvalid_o, channel_enable_o, table_load_o;
    logic             table_entry_write_i, table_load_done_i, negotiation_done_i;
    logic             negotiation_pending_o, arbitration_table_dirty_o;
    svrc_cfg_req_type cfg_req_i;
    logic [31:0]      cfg_rdata_o;
    logic [2:0]       channel_identifier_o, port_arbitration_scheme_select_o;
    logic [7:0]       scheme_onehot_o, traffic_class_map_o, port_arbitration_capability_o;
    int               fail_count, num_checks;
    svrc_control svrc_control_i (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] b, input logic [31:0] d);
        @(negedge clk_sys_i) cfg_req_i = '{1'b0, 1'b1, 12'h170, b, d};
        @(negedge clk_sys_i) cfg_req_i = '0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge clk_sys_i) cfg_req_i = '{1'b1, 1'b0, a, 4'hf, 32'h0};
        @(negedge clk_sys_i) cfg_req_i = '0;
        chk(cfg_rvalid_o, 1'b1);
        chk(cfg_rdata_o, exp);
    endtask : rd
    task automatic sc_reset;
        chk({channel_enable_o, negotiation_pending_o, table_load_o}, 3'h0);
        chk(channel_identifier_o, 3'h1);
        chk(scheme_onehot_o, 8'h01);
        chk(traffic_class_map_o, 8'h00);
        chk(port_arbitration_capability_o, 8'h11);
        rd(12'h170, 32'h0100_0000);
        rd(12'h174, 32'h0);
    endtask : sc_reset
    task automatic sc_fields;
        wr(4'hf, 32'hfff9_ffff);
        chk({channel_enable_o, negotiation_pending_o, table_load_o}, 3'h7);
        chk(scheme_onehot_o, 8'h10);
        @(negedge clk_sys_i) chk(table_load_o, 1'b0);
        rd(12'h170, 32'h8708_00fe);
        negotiation_done_i = 1'b1;
        @(negedge clk_sys_i) negotiation_done_i = 1'b0;
        chk(negotiation_pending_o, 1'b0);
        wr(4'hf, 32'h0);
        rd(12'h170, 32'h0700_0000);
        wr(4'h4, 32'h0008_0000);
        chk({port_arbitration_scheme_select_o, scheme_onehot_o}, {3'h4, 8'h10});
        wr(4'h1, 32'h0000_0055);
        chk(traffic_class_map_o, 8'h54);
        rd(12'h170, 32'h0708_0054);
    endtask : sc_fields
    task automatic sc_flags;
        table_entry_write_i = 1'b1;
        @(negedge clk_sys_i) table_entry_write_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk(arbitration_table_dirty_o, 1'b1);
        table_load_done_i = 1'b1;
        @(negedge clk_sys_i) table_load_done_i = 1'b0;
        chk(arbitration_table_dirty_o, 1'b0);
    endtask : sc_flags
    task automatic give_verdict;
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        reset_i = 1'b1;
        cfg_req_i = '0;
        {table_entry_write_i, table_load_done_i, negotiation_done_i} = 3'h0;
        repeat (6) @(negedge clk_sys_i);
        reset_i = 1'b0;
        sc_reset();
        sc_fields();
        sc_flags();
        give_verdict();
    end
endmodule : tb
